// [core/jrm_pkg.sv]
// constants and types for the test-reset and debug-mode latch block
`default_nettype none

package jrm_pkg;

  // ****************************************************************
  // widths and reset levels
  // ****************************************************************
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_RST = 2'h0;
  // test reset pin reads low when undriven, so the flops start asserted
  localparam logic TRST_N_RST = 1'h0;
  localparam logic SYS_N_RST = 1'h0;
  localparam logic TCK_RST = 1'h0;
  localparam logic ASSERTED = 1'h1;
  localparam logic RELEASED = 1'h0;

  // ****************************************************************
  // debug-mode select encoding
  // ****************************************************************
  // pin code that picks emulation; any other code picks boundary scan
  localparam logic [1:0] MODE_EMU_CODE = 2'h3;

  // ****************************************************************
  // test port state
  // ****************************************************************
  typedef enum logic {
    JRM_TS_HELD,
    JRM_TS_ACTIVE
  } jrm_tstate_e;

endpackage

`default_nettype wire

// [core/jrm_sync3.sv]
// three-flop pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`default_nettype none

module jrm_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pin side
  input wire logic [WIDTH-1:0] pin_i,
  // clean side
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // first stage feeds only the second
  always_comb begin
    q_nxt = q_r;
    if (s2_r == s3_r) begin
      q_nxt = s3_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule

`default_nettype wire

// [core/jrm_top.sv]
// test reset domain split and debug-mode select latch
`timescale 1ns/1ps
`default_nettype none

module jrm_top (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pins from the board and the debug probe
  input wire logic sys_rst_n_i,
  input wire logic trst_n_i,
  input wire logic tck_i,
  input wire logic [1:0] debug_mode_select_pins_i,
  // reset domains
  output logic func_rst_o,
  output logic test_rst_o,
  // test port status
  output logic tap_enable_o,
  output logic id_variant_valid_o,
  output logic trst_pulldown_en_o,
  // latched debug mode
  output logic [1:0] debug_mode_o,
  output logic mode_latched_o,
  output logic mode_emu_o,
  output logic mode_bscan_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic sys_n_s;
  logic trst_n_s;
  logic tck_s;
  logic [1:0] mode_s;

  jrm_sync3 #(
    .WIDTH(1),
    .RST_VAL(jrm_pkg::SYS_N_RST)
  ) u_sync_sys (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(sys_rst_n_i),
    .q_o(sys_n_s)
  );

  // reset value low: an undriven pin reads as an asserted test reset
  jrm_sync3 #(
    .WIDTH(1),
    .RST_VAL(jrm_pkg::TRST_N_RST)
  ) u_sync_trst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(trst_n_i),
    .q_o(trst_n_s)
  );

  jrm_sync3 #(
    .WIDTH(1),
    .RST_VAL(jrm_pkg::TCK_RST)
  ) u_sync_tck (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(tck_i),
    .q_o(tck_s)
  );

  jrm_sync3 #(
    .WIDTH(jrm_pkg::MODE_W),
    .RST_VAL(jrm_pkg::MODE_RST)
  ) u_sync_mode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(debug_mode_select_pins_i),
    .q_o(mode_s)
  );

  // ****************************************************************
  // test clock edge detect
  // ****************************************************************
  logic tck_prev_r;
  logic tck_prev_nxt;
  logic tck_rise;

  always_comb begin
    tck_prev_nxt = tck_s;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_prev_r <= jrm_pkg::TCK_RST;
    end else if (ce_i) begin
      tck_prev_r <= tck_prev_nxt;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_r;

  // ****************************************************************
  // reset domains and test port state
  // ****************************************************************
  jrm_pkg::jrm_tstate_e state_r;
  jrm_pkg::jrm_tstate_e state_nxt;
  logic func_rst_r;
  logic func_rst_nxt;
  logic test_rst_r;
  logic test_rst_nxt;
  logic tap_en_r;
  logic tap_en_nxt;
  logic idv_r;
  logic idv_nxt;
  logic trst_rise;

  always_comb begin
    state_nxt = state_r;
    trst_rise = 1'b0;
    // functional reset ignores the test reset entirely
    func_rst_nxt = ~sys_n_s;
    // test reset only moves on a test clock edge; a stopped clock freezes it
    if (tck_rise) begin
      case (state_r)
        jrm_pkg::JRM_TS_HELD: begin
          if (trst_n_s) begin
            state_nxt = jrm_pkg::JRM_TS_ACTIVE;
            trst_rise = 1'b1;
          end
        end
        jrm_pkg::JRM_TS_ACTIVE: begin
          if (!trst_n_s) begin
            state_nxt = jrm_pkg::JRM_TS_HELD;
          end
        end
        default: begin
          state_nxt = jrm_pkg::JRM_TS_HELD;
        end
      endcase
    end
    test_rst_nxt = (state_nxt == jrm_pkg::JRM_TS_HELD);
    // one port for scan and emulation, enabled regardless of system reset
    tap_en_nxt = (state_nxt == jrm_pkg::JRM_TS_ACTIVE);
    // id variant field needs the functional side out of reset
    idv_nxt = ~func_rst_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= jrm_pkg::JRM_TS_HELD;
      func_rst_r <= jrm_pkg::ASSERTED;
      test_rst_r <= jrm_pkg::ASSERTED;
      tap_en_r <= jrm_pkg::RELEASED;
      idv_r <= jrm_pkg::RELEASED;
    end else if (ce_i) begin
      state_r <= state_nxt;
      func_rst_r <= func_rst_nxt;
      test_rst_r <= test_rst_nxt;
      tap_en_r <= tap_en_nxt;
      idv_r <= idv_nxt;
    end
  end

  // ****************************************************************
  // debug-mode latch
  // ****************************************************************
  logic latch_ev;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic latched_r;
  logic latched_nxt;
  logic emu_r;
  logic emu_nxt;
  logic bscan_r;
  logic bscan_nxt;
  logic pd_r;

  // a rise seen while system reset is still low is not a capture
  assign latch_ev = ce_i & trst_rise & ~func_rst_r;

  always_comb begin
    mode_nxt = mode_r;
    latched_nxt = latched_r;
    if (latch_ev) begin
      mode_nxt = mode_s;
      latched_nxt = 1'b1;
    end
    // decode from the latch, never from the live pins
    emu_nxt = latched_nxt & (mode_nxt == jrm_pkg::MODE_EMU_CODE);
    bscan_nxt = latched_nxt & (mode_nxt != jrm_pkg::MODE_EMU_CODE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= jrm_pkg::MODE_RST;
      latched_r <= jrm_pkg::RELEASED;
      emu_r <= jrm_pkg::RELEASED;
      bscan_r <= jrm_pkg::RELEASED;
      pd_r <= jrm_pkg::ASSERTED;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
      latched_r <= latched_nxt;
      emu_r <= emu_nxt;
      bscan_r <= bscan_nxt;
      pd_r <= jrm_pkg::ASSERTED;
    end
  end

  assign func_rst_o = func_rst_r;
  assign test_rst_o = test_rst_r;
  assign tap_enable_o = tap_en_r;
  assign id_variant_valid_o = idv_r;
  assign trst_pulldown_en_o = pd_r;
  assign debug_mode_o = mode_r;
  assign mode_latched_o = latched_r;
  assign mode_emu_o = emu_r;
  assign mode_bscan_o = bscan_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_func_rst_follow: assert property (
    (ce_i && !sys_n_s) |=> func_rst_o && !id_variant_valid_o)
    else $error("functional reset did not follow system reset");

  chk_boot_indep: assert property (
    (ce_i && sys_n_s && test_rst_o) |=> !func_rst_o)
    else $error("boot blocked by test reset");

  chk_trst_tck_only: assert property (
    (ce_i && !tck_rise) |=> $stable(test_rst_o) && $stable(tap_enable_o))
    else $error("test reset moved without a test clock edge");

  chk_trst_held: assert property (
    (ce_i && tck_rise && !trst_n_s) |=> test_rst_o ##1 !tap_enable_o)
    else $error("test port left reset while pin held low");

  chk_trst_release: assert property (
    (ce_i && tck_rise && trst_n_s) |=> !test_rst_o && tap_enable_o)
    else $error("test port not released on sampled high");

  chk_variant_valid: assert property (
    id_variant_valid_o |-> !func_rst_o)
    else $error("id variant valid during system reset");

  chk_mode_capture: assert property (
    latch_ev |=> mode_latched_o && debug_mode_o == $past(mode_s))
    else $error("mode pins not captured on test reset rise");

  chk_mode_qualify: assert property (
    (ce_i && trst_rise && func_rst_r) |=> $stable(debug_mode_o))
    else $error("mode captured while system reset asserted");

  chk_mode_hold: assert property (
    !latch_ev |=> $stable(debug_mode_o))
    else $error("latched mode changed without capture");

  chk_mode_decode: assert property (
    mode_latched_o |-> (mode_emu_o ^ mode_bscan_o) &&
      (mode_emu_o == (debug_mode_o == jrm_pkg::MODE_EMU_CODE)))
    else $error("mode decode does not match latch");

  chk_pulldown_on: assert property (
    trst_pulldown_en_o)
    else $error("test reset pulldown not enabled");

  chk_reset_state: assert property (disable iff (1'b0)
    rst_i |=> test_rst_o && func_rst_o && !mode_latched_o)
    else $error("reset state wrong");

  cov_boot_trst_low: cover property (
    !func_rst_o && test_rst_o [*8]);

  cov_emu_latch: cover property (
    latch_ev ##1 mode_emu_o);

  cov_bscan_latch: cover property (
    latch_ev ##1 mode_bscan_o);

  cov_ignored_rise: cover property (
    ce_i && trst_rise && func_rst_r);

endmodule

`default_nettype wire

// [tb/jrm_probe_model.sv]
// debug probe model: test clock, test reset and mode pins
`timescale 1ns/1ps
`default_nettype none

module jrm_probe_model (
  // pacing clock
  input wire logic clk_i,
  // pins toward the device
  output logic tck_o,
  output var logic trst_n_o,
  output logic [1:0] mode_o
);
  logic drv_en;
  logic drv_val;

  // a released test reset line falls to the pad pulldown
  assign trst_n_o = drv_en ? drv_val : 1'b0;

  initial begin
    tck_o = 1'b0;
    drv_en = 1'b1;
    drv_val = 1'b0;
    mode_o = 2'h0;
  end

  // ****************************************************************
  // pin tasks
  // ****************************************************************
  // test reset held low: test port and emulation logic stay in reset
  task automatic trst_low();
    @(negedge clk_i);
    drv_en = 1'b1;
    drv_val = 1'b0;
  endtask

  // controller drives the line high before any scan or debug work
  task automatic trst_high();
    @(negedge clk_i);
    drv_en = 1'b1;
    drv_val = 1'b1;
  endtask

  // controller lets go of the line: pad pulldown wins
  task automatic trst_float();
    @(negedge clk_i);
    drv_en = 1'b0;
    drv_val = 1'b0;
  endtask

  task automatic set_mode(input logic [1:0] val);
    @(negedge clk_i);
    mode_o = val;
  endtask

  // clock stands low between bursts; 80 ns period, moved on falling edges
  task automatic run_tck(input int n);
    repeat (8) @(negedge clk_i);
    repeat (n) begin
      tck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      tck_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// [tb/jrm_top_tb_top.sv]
// self-checking bench for the test reset and mode latch block
`timescale 1ns/1ps
`default_nettype none

module jrm_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic sys_rst_n_i = 1'b0;
  logic tck_i, trst_n_i;
  logic [1:0] pins;
  logic func_rst_o, test_rst_o, tap_enable_o, id_variant_valid_o;
  logic trst_pulldown_en_o, mode_latched_o, mode_emu_o, mode_bscan_o;
  logic [1:0] debug_mode_o;
  int errors = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  jrm_top i_jrm_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .sys_rst_n_i(sys_rst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i),
    .debug_mode_select_pins_i(pins),
    .func_rst_o(func_rst_o), .test_rst_o(test_rst_o),
    .tap_enable_o(tap_enable_o), .id_variant_valid_o(id_variant_valid_o),
    .trst_pulldown_en_o(trst_pulldown_en_o), .debug_mode_o(debug_mode_o),
    .mode_latched_o(mode_latched_o), .mode_emu_o(mode_emu_o),
    .mode_bscan_o(mode_bscan_o)
  );

  jrm_probe_model i_jrm_probe_model (
    .clk_i(clk_i), .tck_o(tck_i), .trst_n_o(trst_n_i), .mode_o(pins)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string name, input logic [1:0] seen,
                       input logic [1:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic sys_hold();
    @(negedge clk_i);
    sys_rst_n_i = 1'b0;
  endtask

  task automatic sys_free();
    @(negedge clk_i);
    sys_rst_n_i = 1'b1;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values();
    rst_i = 1'b1;
    wait_clk(5);
    rst_i = 1'b0;
    check("func_rst", {1'b0, func_rst_o}, 2'h1);
    check("test_rst", {1'b0, test_rst_o}, 2'h1);
    check("tap_en", {1'b0, tap_enable_o}, 2'h0);
    check("id_valid", {1'b0, id_variant_valid_o}, 2'h0);
    check("pulldown", {1'b0, trst_pulldown_en_o}, 2'h1);
    check("mode", debug_mode_o, 2'h0);
    check("latched", {mode_emu_o, mode_latched_o}, 2'h0);
  endtask

  task automatic t_boot_held();
    sys_free();
    i_jrm_probe_model.run_tck(3);
    wait_clk(8);
    check("func_rst", {1'b0, func_rst_o}, 2'h0);
    check("id_valid", {1'b0, id_variant_valid_o}, 2'h1);
    check("test_rst", {1'b0, test_rst_o}, 2'h1);
    check("tap_en", {1'b0, tap_enable_o}, 2'h0);
    check("latched", {1'b0, mode_latched_o}, 2'h0);
  endtask

  task automatic t_capture_codes();
    logic [1:0] e;
    for (int c = 0; c < 4; c++) begin
      i_jrm_probe_model.trst_low();
      i_jrm_probe_model.run_tck(2);
      wait_clk(8);
      check("test_rst", {1'b0, test_rst_o}, 2'h1);
      i_jrm_probe_model.set_mode(c[1:0]);
      i_jrm_probe_model.trst_high();
      i_jrm_probe_model.run_tck(2);
      wait_clk(8);
      e = {c[1:0] == jrm_pkg::MODE_EMU_CODE, c[1:0] != jrm_pkg::MODE_EMU_CODE};
      check("tap_en", {test_rst_o, tap_enable_o}, 2'h1);
      check("mode", debug_mode_o, c[1:0]);
      check("emu_bscan", {mode_emu_o, mode_bscan_o}, e);
      i_jrm_probe_model.set_mode(~c[1:0]);
      i_jrm_probe_model.run_tck(2);
      wait_clk(8);
      check("mode_hold", debug_mode_o, c[1:0]);
      check("emu_hold", {mode_emu_o, mode_bscan_o}, e);
    end
  endtask

  task automatic t_tck_stopped();
    i_jrm_probe_model.trst_low();
    wait_clk(20);
    check("test_rst", {1'b0, test_rst_o}, 2'h0);
    i_jrm_probe_model.run_tck(1);
    wait_clk(8);
    check("test_rst", {1'b0, test_rst_o}, 2'h1);
  endtask

  task automatic t_early_release();
    sys_hold();
    t_reset_values();
    i_jrm_probe_model.set_mode(jrm_pkg::MODE_EMU_CODE);
    i_jrm_probe_model.trst_float();
    i_jrm_probe_model.run_tck(2);
    i_jrm_probe_model.trst_high();
    i_jrm_probe_model.run_tck(2);
    wait_clk(8);
    check("tap_en", {func_rst_o, tap_enable_o}, 2'h3);
    check("latched", {1'b0, mode_latched_o}, 2'h0);
    sys_free();
    i_jrm_probe_model.run_tck(2);
    wait_clk(8);
    check("latched", {func_rst_o, mode_latched_o}, 2'h0);
    i_jrm_probe_model.trst_low();
    i_jrm_probe_model.run_tck(2);
    i_jrm_probe_model.trst_high();
    i_jrm_probe_model.run_tck(2);
    wait_clk(8);
    check("latched", {mode_emu_o, mode_latched_o}, 2'h3);
    check("mode", debug_mode_o, 2'h3);
  endtask

  // clock enable low freezes every flop, synchronisers included
  task automatic t_ce_freeze();
    wait_clk(1);
    ce_i = 1'b0;
    i_jrm_probe_model.trst_low();
    sys_hold();
    i_jrm_probe_model.run_tck(2);
    wait_clk(8);
    check("frozen", {func_rst_o, test_rst_o}, 2'h0);
    check("frozen_tap", {tap_enable_o, mode_latched_o}, 2'h3);
    wait_clk(1);
    ce_i = 1'b1;
    wait_clk(8);
    check("ce_run", {func_rst_o, test_rst_o}, 2'h2);
    i_jrm_probe_model.run_tck(1);
    wait_clk(8);
    check("ce_run", {func_rst_o, test_rst_o}, 2'h3);
  endtask

  initial begin
    t_reset_values();
    t_boot_held();
    t_capture_codes();
    t_tck_stopped();
    t_early_release();
    t_ce_freeze();
    final_report();
  end

  // whole run is about seven microseconds
  initial begin
    #200us;
    errors++;
    final_report();
  end
endmodule

`default_nettype wire
